/* inc/gpio_pkg.sv */
// Shared constants and types of the general-purpose port array
package gpio_pkg;
  localparam int NPORT = 12;
  localparam int PW = 8;
  localparam int NEXT = 8;
  localparam int NSRC = 12;
  localparam int NDET = 22;
  // Port positions in the packed arrays: 0..7 numeric ports, then A, B, C, D
  localparam int PORT_A = 8;
  localparam int PORT_B = 9;
  localparam int PORT_C = 10;
  localparam int PORT_D = 11;
  // Interrupt source positions
  localparam int SRC_P0_GROUP = 8;
  localparam int SRC_P04 = 9;
  localparam int SRC_P05 = 10;
  localparam int SRC_P5 = 11;
  // Detector channel positions
  localparam int DET_P0_LOW = 8;
  localparam int DET_P04 = 12;
  localparam int DET_P05 = 13;
  localparam int DET_P5 = 14;
  // Implemented pins per port, port D first
  localparam logic [NPORT-1:0][PW-1:0] IMPL_MASK = {8'h3f, 8'h1f, 8'h7f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // Pins with a pull-up switch; the oscillator pins of port C have none
  localparam logic [NPORT-1:0][PW-1:0] PULL_MASK = {8'h3f, 8'h04, 8'h7f, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  // Pins whose output may be switched to open drain
  localparam logic [NPORT-1:0][PW-1:0] OD_MASK = {8'h00, 8'h00, 8'h7f, 8'hff,
    8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  // Pin that carries each external interrupt line, lines a to h
  localparam int EXT_PORT [NEXT] = '{3, 3, 3, 3, 2, 2, 4, 4};
  localparam int EXT_BIT [NEXT] = '{0, 1, 2, 3, 0, 1, 0, 1};
  localparam logic [PW-1:0] RST_PORT = 8'h00;
  localparam logic [NSRC-1:0] RST_IRQ = 12'h000;

  typedef enum logic [2:0] {TRIG_HIGH, TRIG_LOW, TRIG_RISE, TRIG_FALL, TRIG_BOTH} trig_t;
endpackage : gpio_pkg

/* inc/trig_if.sv */
// Carrier between the port array and its trigger detector
interface trig_if #(parameter int N = 22);
  logic [N-1:0] level;
  gpio_pkg::trig_t [N-1:0] mode;
  logic [N-1:0] hit;
  modport src (output level, output mode, input hit);
  modport det (input level, input mode, output hit);
endinterface : trig_if

/* rtl/trig_detect.sv */
// Level and edge trigger detector for the interrupt inputs
module trig_detect #(parameter int N = 22) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  trig_if.det t
);
  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;
  logic valid_q;
  logic valid_d;
  logic [N-1:0] hit;

  always_comb begin
    prev_d = prev_q;
    valid_d = valid_q;
    if (ce) begin
      prev_d = t.level;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
      valid_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      valid_q <= valid_d;
    end
  end

  // No edge is reported before a first sample has been taken
  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (t.mode[i])
        gpio_pkg::TRIG_HIGH: hit[i] = t.level[i];
        gpio_pkg::TRIG_LOW: hit[i] = ~t.level[i];
        gpio_pkg::TRIG_RISE: hit[i] = valid_q & t.level[i] & ~prev_q[i];
        gpio_pkg::TRIG_FALL: hit[i] = valid_q & ~t.level[i] & prev_q[i];
        gpio_pkg::TRIG_BOTH: hit[i] = valid_q & (t.level[i] ^ prev_q[i]);
        default: hit[i] = 1'b0;
      endcase
    end
  end

  assign t.hit = hit;

  chk_edge_needs_change: assert property (@(posedge clk) disable iff (!rst_n)
    (t.mode[0] == gpio_pkg::TRIG_RISE && $stable(t.level[0]) && $past(ce)) |-> !hit[0])
    else $error("rising trigger fired without a change");
endmodule : trig_detect

/* rtl/port_array.sv */
// General-purpose port array: direction, pull-up, drive type, readback, triggers
// Functional notes
// - Every pin of an eight-pin port has its own direction control.
// - Every pin except the port C oscillator pins has its own pull-up enable.
// - Port reads return real pin levels, also on driven outputs.
// - Eight external lines trigger on high, low, rising, falling or both edges.
// - External interrupt lines also wake the device from deep standby.
// - Port zero interrupts: low four pins grouped, fifth and sixth alone; all wake.
// - Port five raises one interrupt from its eight pins, which can also wake.
// - Ports one to four, A and B choose push-pull or open drain per pin.
// - Port C oscillator pins have no pull-up and drive push-pull only.
module port_array #(
  parameter int NP = gpio_pkg::NPORT,
  parameter int PW = gpio_pkg::PW
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [NP-1:0][PW-1:0] pin_in,
  input wire logic [NP-1:0][PW-1:0] dir,
  input wire logic [NP-1:0][PW-1:0] dout,
  input wire logic [NP-1:0][PW-1:0] pull_en,
  input wire logic [NP-1:0][PW-1:0] od_sel,
  input wire logic [NP-1:0][PW-1:0] periph_sel,
  input wire logic [NP-1:0][PW-1:0] periph_out,
  input wire logic [NP-1:0][PW-1:0] periph_oe,
  input wire logic [gpio_pkg::NEXT-1:0][2:0] ext_mode,
  input wire logic [2:0][2:0] p0_mode,
  input wire logic [2:0] p5_mode,
  input wire logic [gpio_pkg::NSRC-1:0] irq_en,
  input wire logic standby,
  output logic [NP-1:0][PW-1:0] pin_out_q,
  output logic [NP-1:0][PW-1:0] pin_oe_q,
  output logic [NP-1:0][PW-1:0] pull_on_q,
  output logic [NP-1:0][PW-1:0] pin_rd_q,
  output logic [NP-1:0][PW-1:0] periph_in_q,
  output logic [gpio_pkg::NSRC-1:0] irq_q,
  output logic wake_q
);
  logic [1:0] rs_q;
  logic rst_n;
  logic [NP-1:0][PW-1:0] out_d;
  logic [NP-1:0][PW-1:0] oe_d;
  logic [NP-1:0][PW-1:0] pull_d;
  logic [NP-1:0][PW-1:0] rd_d;
  logic [NP-1:0][PW-1:0] pin_in_d;
  logic [gpio_pkg::NSRC-1:0] src_hit;
  logic [gpio_pkg::NSRC-1:0] irq_d;
  logic wake_d;

  trig_if #(.N(gpio_pkg::NDET)) tif ();

  // Returns {drive level, output enable} of one pin
  function automatic logic [1:0] pin_drive(input logic impl, input logic od_ok,
                                           input logic dir_b, input logic od_b,
                                           input logic data, input logic psel,
                                           input logic pout, input logic poe);
    logic val;
    logic en;
    val = psel ? pout : data;
    en = psel ? poe : dir_b;
    if (od_ok && od_b) begin
      // Open drain only ever pulls low
      pin_drive = {1'b0, impl & en & ~val};
    end else begin
      pin_drive = {impl & val, impl & en};
    end
  endfunction : pin_drive

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end

  assign rst_n = rs_q[1];

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      for (int b = 0; b < PW; b++) begin
        {out_d[p][b], oe_d[p][b]} = pin_drive(gpio_pkg::IMPL_MASK[p][b],
          gpio_pkg::OD_MASK[p][b], dir[p][b], od_sel[p][b], dout[p][b],
          periph_sel[p][b], periph_out[p][b], periph_oe[p][b]);
      end
      pull_d[p] = pull_en[p] & gpio_pkg::PULL_MASK[p];
      rd_d[p] = pin_in[p] & gpio_pkg::IMPL_MASK[p];
      pin_in_d[p] = rd_d[p];
    end
  end

  // Trigger channels: external lines, port zero pins, port five pins
  always_comb begin
    for (int i = 0; i < gpio_pkg::NEXT; i++) begin
      tif.level[i] = pin_in[gpio_pkg::EXT_PORT[i]][gpio_pkg::EXT_BIT[i]];
      tif.mode[i] = gpio_pkg::trig_t'(ext_mode[i]);
    end
    for (int i = 0; i < 4; i++) begin
      tif.level[gpio_pkg::DET_P0_LOW + i] = pin_in[0][i];
      tif.mode[gpio_pkg::DET_P0_LOW + i] = gpio_pkg::trig_t'(p0_mode[0]);
    end
    tif.level[gpio_pkg::DET_P04] = pin_in[0][4];
    tif.mode[gpio_pkg::DET_P04] = gpio_pkg::trig_t'(p0_mode[1]);
    tif.level[gpio_pkg::DET_P05] = pin_in[0][5];
    tif.mode[gpio_pkg::DET_P05] = gpio_pkg::trig_t'(p0_mode[2]);
    for (int i = 0; i < PW; i++) begin
      tif.level[gpio_pkg::DET_P5 + i] = pin_in[5][i];
      tif.mode[gpio_pkg::DET_P5 + i] = gpio_pkg::trig_t'(p5_mode);
    end
  end

  trig_detect #(.N(gpio_pkg::NDET)) u_detect (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .t(tif.det)
  );

  always_comb begin
    src_hit[gpio_pkg::NEXT-1:0] = tif.hit[gpio_pkg::NEXT-1:0];
    src_hit[gpio_pkg::SRC_P0_GROUP] = |tif.hit[gpio_pkg::DET_P0_LOW +: 4];
    src_hit[gpio_pkg::SRC_P04] = tif.hit[gpio_pkg::DET_P04];
    src_hit[gpio_pkg::SRC_P05] = tif.hit[gpio_pkg::DET_P05];
    src_hit[gpio_pkg::SRC_P5] = |tif.hit[gpio_pkg::DET_P5 +: 8];
    irq_d = ce ? (src_hit & irq_en) : irq_q;
    wake_d = wake_q;
    // Held while in standby; cleared on the first ce cycle with standby low, so a new hit in that cycle is lost
    if (ce) begin
      wake_d = standby & (wake_q | (|(src_hit & irq_en)));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      pull_on_q <= '0;
      pin_rd_q <= '0;
      periph_in_q <= '0;
      irq_q <= gpio_pkg::RST_IRQ;
      wake_q <= 1'b0;
    end else begin
      if (ce) begin
        pin_out_q <= out_d;
        pin_oe_q <= oe_d;
        pull_on_q <= pull_d;
        pin_rd_q <= rd_d;
        periph_in_q <= pin_in_d;
      end
      irq_q <= irq_d;
      wake_q <= wake_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_dir_input: assert property (ce && dir[0] == 8'h00 && periph_sel[0] == 8'h00
    |=> pin_oe_q[0] == 8'h00) else $error("input pins driven");
  chk_pull_ctl: assert property (ce |=> pull_on_q[1] == $past(pull_en[1]))
    else $error("pull-up does not follow its enable");
  chk_pin_read: assert property (ce && dir[0] == 8'hff |=> pin_rd_q[0] == $past(pin_in[0]))
    else $error("readback differs from pins");
  chk_rise_irq: assert property ((ce && ext_mode[0] == 3'h2 && irq_en[0] && !pin_in[3][0])
    ##1 (ce && ext_mode[0] == 3'h2 && irq_en[0] && pin_in[3][0]) |=> irq_q[0])
    else $error("rising edge not reported");
  chk_low_level: assert property (ce && ext_mode[1] == 3'h1 && irq_en[1] && !pin_in[3][1]
    |=> irq_q[1]) else $error("low level not reported");
  chk_wake_hold: assert property (wake_q && standby |=> wake_q)
    else $error("wake dropped during standby");
  chk_p0_group: assert property (ce && p0_mode[0] == 3'h0 && irq_en[8] && pin_in[0][2]
    |=> irq_q[8]) else $error("port zero group missed");
  chk_p5_wake: assert property (ce && standby && p5_mode == 3'h0 && irq_en[11]
    && pin_in[5] != 8'h00 |=> wake_q ##1 (wake_q || !$past(standby)))
    else $error("port five did not wake");
  chk_open_drain: assert property (ce && od_sel[1][0] && dir[1][0] && !periph_sel[1][0]
    && dout[1][0] |=> !pin_oe_q[1][0] && !pin_out_q[1][0])
    else $error("open drain drove high");
  chk_port_c_oe: assert property (ce && dir[10][2] && !periph_sel[10][2]
    |=> pin_oe_q[10][2] && pin_oe_q[10][7:5] == 3'h0) else $error("port C enable");
  chk_port_b_width: assert property (pin_oe_q[9][7] == 1'b0 && pull_on_q[9][7] == 1'b0)
    else $error("port B eighth pin active");
  chk_port_d_width: assert property (pin_oe_q[11][7:6] == 2'h0 && pull_on_q[11][7:6] == 2'h0)
    else $error("port D upper pins active");
  chk_osc_pull: assert property (pull_on_q[10][4:3] == 2'h0 && pull_on_q[10][1:0] == 2'h0)
    else $error("oscillator pin pulled up");
  chk_periph_route: assert property (ce && periph_sel[4][6] && !od_sel[4][6]
    |=> pin_out_q[4][6] == $past(periph_out[4][6])) else $error("peripheral not routed");

  cov_ext_edge: cover property (irq_q[0] && !$past(irq_q[0]));
  cov_wake: cover property (standby && wake_q);
  cov_open_drain: cover property (pin_oe_q[1][0] && od_sel[1][0]);
endmodule : port_array

/* test/pin_board.sv */
// Board model: outside drivers and pull-ups seen on the port pins
module pin_board (
  input wire logic clk,
  input wire logic [11:0][7:0] oe,
  input wire logic [11:0][7:0] out,
  input wire logic [11:0][7:0] pull,
  input wire logic [11:0][7:0] drv,
  input wire logic [11:0][7:0] val,
  output logic [11:0][7:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0][7:0] last_q;
  // A pin nobody drives and nothing pulls shows the inverse of its last level
  always_comb begin
    lvl = (oe & out) | (~oe & drv & val) | (~oe & ~drv & pull) | (~oe & ~drv & ~pull & ~last_q);
  end
  always_ff @(posedge clk) begin
    last_q <= lvl;
  end
endmodule : pin_board

/* test/general_purpose_port_array_bench.sv */
// Self-checking bench of the general-purpose port array
module general_purpose_port_array_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int p; logic [7:0] d; logic [7:0] o; logic [7:0] u; logic [7:0] s;
    logic [7:0] x;} row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic standby = 1'b0;
  logic [11:0][7:0] dir = '0, dout = '0, pull = '0, od = '0, psel = '0, pout = '0, poe = '0;
  logic [11:0][7:0] val = '0;
  logic [11:0][7:0] drv = '1;
  logic [11:0][7:0] lvl, oe_q, out_q, pu_q, rd_q, pi_q;
  logic [7:0][2:0] ext_mode = '0;
  logic [2:0][2:0] p0_mode = '0;
  logic [2:0] p5_mode = 3'h0;
  logic [11:0] irq_en = '1;
  logic [11:0] irq_q;
  logic wake_q;
  int miscompares = 0;
  int checks_done = 0;
  int sp [12] = '{3, 3, 3, 3, 2, 2, 4, 4, 0, 0, 0, 5};
  int sb [12] = '{0, 1, 2, 3, 0, 1, 0, 1, 2, 4, 5, 7};
  row_t rows [6] = '{
    '{0, 8'ha5, 8'h3c, 8'h0f, 8'hff, 8'h0f},
    '{1, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f},
    '{8, 8'h0f, 8'h05, 8'hf0, 8'hff, 8'h33},
    '{9, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00},
    '{10, 8'h1f, 8'h15, 8'hff, 8'hff, 8'h00},
    '{11, 8'hff, 8'h2a, 8'hff, 8'hff, 8'h00}
  };

  always #2 clk = ~clk;

  pin_board board (.clk(clk), .oe(oe_q), .out(out_q), .pull(pu_q), .drv(drv), .val(val),
    .lvl(lvl));

  port_array dut (.clk(clk), .nrst(nrst), .ce(ce), .pin_in(lvl), .dir(dir), .dout(dout),
    .pull_en(pull), .od_sel(od), .periph_sel(psel), .periph_out(pout), .periph_oe(poe),
    .ext_mode(ext_mode), .p0_mode(p0_mode), .p5_mode(p5_mode), .irq_en(irq_en),
    .standby(standby), .pin_out_q(out_q), .pin_oe_q(oe_q), .pull_on_q(pu_q),
    .pin_rd_q(rd_q), .periph_in_q(pi_q), .irq_q(irq_q), .wake_q(wake_q));

  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    #20000;
    miscompares++;
    close_out();
  end

  initial begin
    @(negedge clk);
    chk("reset irq", 12'h000, irq_q);
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      row_t r;
      logic [7:0] odm, eoe, eout;
      r = rows[i];
      dir = '0;
      dout = '0;
      pull = '0;
      od = '0;
      val = '0;
      dir[r.p] = r.d;
      dout[r.p] = r.o;
      pull[r.p] = r.u;
      od[r.p] = r.s;
      val[r.p] = r.x;
      odm = r.s & gpio_pkg::OD_MASK[r.p];
      eoe = r.d & gpio_pkg::IMPL_MASK[r.p] & ~(odm & r.o);
      eout = r.o & ~odm & eoe;
      repeat (3) @(negedge clk);
      chk("drive enable", eoe, oe_q[r.p]);
      chk("drive level", eout, out_q[r.p] & eoe);
      chk("pull", r.u & gpio_pkg::PULL_MASK[r.p], pu_q[r.p]);
      chk("readback", gpio_pkg::IMPL_MASK[r.p] & ((eoe & eout) | (~eoe & r.x)), rd_q[r.p]);
      chk("peripheral input", rd_q[r.p], pi_q[r.p]);
    end
    dir = '0;
    psel[6][0] = 1'b1;
    pout[6][0] = 1'b1;
    poe[6][0] = 1'b1;
    repeat (2) @(negedge clk);
    chk("peripheral drive", 12'h001, {oe_q[6][0], out_q[6][0]} == 2'b11);
    psel = '0;
    ce = 1'b0;
    dir[7] = 8'hff;
    repeat (3) @(negedge clk);
    chk("frozen", 12'h000, oe_q[7]);
    ce = 1'b1;
    dir = '0;
    standby = 1'b1;
    for (int m = 0; m < 5; m++) begin
      ext_mode[0] = m[2:0];
      val[3][0] = 1'b0;
      repeat (3) @(negedge clk);
      val[3][0] = 1'b1;
      @(negedge clk);
      chk("after rise", 12'((5'b10101 >> m) & 5'h1), irq_q & 12'h001);
      @(negedge clk);
      chk("rise held", 12'((5'b00001 >> m) & 5'h1), irq_q & 12'h001);
      val[3][0] = 1'b0;
      @(negedge clk);
      chk("after fall", 12'((5'b11010 >> m) & 5'h1), irq_q & 12'h001);
      @(negedge clk);
    end
    chk("wake", 12'h001, {11'h0, wake_q});
    standby = 1'b0;
    repeat (2) @(negedge clk);
    chk("wake off", 12'h000, {11'h0, wake_q});
    ext_mode = {8{3'h2}};
    p0_mode = {3{3'h2}};
    p5_mode = 3'h2;
    for (int s = 0; s < 12; s++) begin
      val = '0;
      repeat (2) @(negedge clk);
      val[sp[s]][sb[s]] = 1'b1;
      @(negedge clk);
      chk("source", 12'h001 << s, irq_q);
    end
    close_out();
  end
endmodule : general_purpose_port_array_bench
